// *** design/port_direction_data_pullup.sv ***
/*
 * Port block for ports 2, 3 and 12: register decode, readback and the
 * three port units.
 * Assumes the CPU gives one-cycle read and write strobes with a byte
 * address, and the clock controller flags when the oscillator owns the
 * two port 12 clock pins.
 */
// Operation
// - Each direction bit picks its pin: 0 drives output, 1 input; port 12 clock pins stay undriven while the oscillator owns them.
// - Reset sets every direction register to all ones, inputs.
// - Direction, data and pull-up registers take bit or byte writes.
// - Data writes go to the output latch, which drives output pins.
// - Reading an input-mode data bit returns the sampled pin level.
// - Reading an output-mode data bit returns the latch, not the pin.
// - Reset clears every data register and output latch.
// - Port 12 clock pins read 0 while the oscillator uses them.
// - Pull-up connects only with select bit 1 and input mode.
// - No pull-up on output pins or alternate outputs.
// - Pull-up selects reset to zero; port 12 resets with bit 5 set.
`timescale 1ns/100ps
`default_nettype none
`include "port_regs.svh"

module port_direction_data_pullup #(
    parameter logic [7:0] PORT2_MASK = `PORT2_IMPL_MASK,
    parameter logic [7:0] PORT3_MASK = `PORT3_IMPL_MASK,
    parameter logic [7:0] PORT3_PU_MASK = `PORT3_PULLUP_MASK
) (
    input wire logic mclk, // 25 MHz system clock
    input wire logic rstn, // Async reset, low
    input wire port_pkg::addr_t bus_addr, // Register address
    input wire logic bus_wr, // Write strobe, one cycle
    input wire logic bus_rd, // Read strobe, one cycle
    input wire logic bus_bit_op, // 1: single-bit write
    input wire port_pkg::bit_idx_t bus_bit_idx, // Bit number
    input wire port_pkg::byte_t bus_wdata, // Write data
    output port_pkg::byte_t bus_rdata, // Read data, registered
    output logic bus_rack, // Read answer pulse
    input wire logic osc_pin_mode, // Oscillator owns clock pins
    input wire port_pkg::byte_t p2_alt_out, // Port 2 alternate outputs
    input wire port_pkg::byte_t p3_alt_out, // Port 3 alternate outputs
    input wire port_pkg::byte_t p12_alt_out, // Port 12 alternate outputs
    input wire port_pkg::byte_t p2_pin_in, // Port 2 pin levels
    output port_pkg::byte_t p2_pin_out, // Port 2 output levels
    output port_pkg::byte_t p2_pin_oe_n, // Port 2 drive, low drives
    output port_pkg::byte_t p2_pullup_on, // Port 2 pull-up connect
    input wire port_pkg::byte_t p3_pin_in, // Port 3 pin levels
    output port_pkg::byte_t p3_pin_out, // Port 3 output levels
    output port_pkg::byte_t p3_pin_oe_n, // Port 3 drive, low drives
    output port_pkg::byte_t p3_pullup_on, // Port 3 pull-up connect
    input wire port_pkg::byte_t p12_pin_in, // Port 12 pin levels
    output port_pkg::byte_t p12_pin_out, // Port 12 output levels
    output port_pkg::byte_t p12_pin_oe_n, // Port 12 drive, low drives
    output port_pkg::byte_t p12_pullup_on // Port 12 pull-up connect
);
    import port_pkg::*;

    // Address decode
    wire hit_p2_dat = bus_addr == `PORT2_DATA_ADDR;
    wire hit_p3_dat = bus_addr == `PORT3_DATA_ADDR;
    wire hit_p12_dat = bus_addr == `PORT12_DATA_ADDR;
    wire hit_p2_dir = bus_addr == `PORT2_DIR_ADDR;
    wire hit_p3_dir = bus_addr == `PORT3_DIR_ADDR;
    wire hit_p12_dir = bus_addr == `PORT12_DIR_ADDR;
    wire hit_p3_pu = bus_addr == `PORT3_PULLUP_ADDR;
    wire hit_p12_pu = bus_addr == `PORT12_PULLUP_ADDR;

    // Write strobes per register
    wire we_p2_dat = bus_wr && hit_p2_dat;
    wire we_p3_dat = bus_wr && hit_p3_dat;
    wire we_p12_dat = bus_wr && hit_p12_dat;
    wire we_p2_dir = bus_wr && hit_p2_dir;
    wire we_p3_dir = bus_wr && hit_p3_dir;
    wire we_p12_dir = bus_wr && hit_p12_dir;
    wire we_p3_pu = bus_wr && hit_p3_pu;
    wire we_p12_pu = bus_wr && hit_p12_pu;

    // Oscillator pins of port 12 are masked only while it owns them
    wire byte_t p12_clk_pins = osc_pin_mode ? `CLK_PIN_MASK : `READ_NONE;

    byte_t p2_dir, p2_dat, p2_pu;
    byte_t p3_dir, p3_dat, p3_pu;
    byte_t p12_dir, p12_dat, p12_pu;
    byte_t rd_sel;

    // Port 2 has no pull-up register, so its select stays cleared
    port_unit #(
        .DIR_MASK(PORT2_MASK),
        .DAT_MASK(PORT2_MASK),
        .PU_MASK(`NO_PULLUP_MASK),
        .PU_RESET(`PULLUP_RESET)
    ) u_port2 (
        .mclk(mclk),
        .rstn(rstn),
        .dir_we(we_p2_dir),
        .dat_we(we_p2_dat),
        .pu_we(1'b0),
        .bit_op(bus_bit_op),
        .bit_idx(bus_bit_idx),
        .wdata(bus_wdata),
        .pin_in(p2_pin_in),
        .alt_out(p2_alt_out),
        .clk_pins(`READ_NONE),
        .dir_rd(p2_dir),
        .dat_rd(p2_dat),
        .pu_rd(p2_pu),
        .pin_out(p2_pin_out),
        .pin_oe_n(p2_pin_oe_n),
        .pullup_on(p2_pullup_on)
    );

    port_unit #(
        .DIR_MASK(PORT3_MASK),
        .DAT_MASK(PORT3_MASK),
        .PU_MASK(PORT3_PU_MASK),
        .PU_RESET(`PULLUP_RESET)
    ) u_port3 (
        .mclk(mclk),
        .rstn(rstn),
        .dir_we(we_p3_dir),
        .dat_we(we_p3_dat),
        .pu_we(we_p3_pu),
        .bit_op(bus_bit_op),
        .bit_idx(bus_bit_idx),
        .wdata(bus_wdata),
        .pin_in(p3_pin_in),
        .alt_out(p3_alt_out),
        .clk_pins(`READ_NONE),
        .dir_rd(p3_dir),
        .dat_rd(p3_dat),
        .pu_rd(p3_pu),
        .pin_out(p3_pin_out),
        .pin_oe_n(p3_pin_oe_n),
        .pullup_on(p3_pullup_on)
    );

    // Bit 5 is input only; its pull-up starts connected
    port_unit #(
        .DIR_MASK(`PORT12_DIR_MASK),
        .DAT_MASK(`PORT12_DATA_MASK),
        .PU_MASK(`PORT12_PULLUP_MASK),
        .PU_RESET(`PORT12_PULLUP_RESET)
    ) u_port12 (
        .mclk(mclk),
        .rstn(rstn),
        .dir_we(we_p12_dir),
        .dat_we(we_p12_dat),
        .pu_we(we_p12_pu),
        .bit_op(bus_bit_op),
        .bit_idx(bus_bit_idx),
        .wdata(bus_wdata),
        .pin_in(p12_pin_in),
        .alt_out(p12_alt_out),
        .clk_pins(p12_clk_pins),
        .dir_rd(p12_dir),
        .dat_rd(p12_dat),
        .pu_rd(p12_pu),
        .pin_out(p12_pin_out),
        .pin_oe_n(p12_pin_oe_n),
        .pullup_on(p12_pullup_on)
    );

    // Read select; an unmapped address reads zero
    assign rd_sel = hit_p2_dat ? p2_dat :
                    hit_p3_dat ? p3_dat :
                    hit_p12_dat ? p12_dat :
                    hit_p2_dir ? p2_dir :
                    hit_p3_dir ? p3_dir :
                    hit_p12_dir ? p12_dir :
                    hit_p3_pu ? p3_pu :
                    hit_p12_pu ? p12_pu : `READ_NONE;

    // Read data is captured at the strobe and held until the next read,
    // so a late pin change cannot tear the value the CPU sees
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            bus_rdata <= `READ_NONE;
            bus_rack <= 1'b0;
        end else begin
            bus_rack <= bus_rd;
            if (bus_rd) bus_rdata <= rd_sel;
        end
    end

    a_clock_pins_zero: assert property (@(posedge mclk) disable iff (!rstn)
        bus_rd && hit_p12_dat && osc_pin_mode |=>
        (bus_rdata & `CLK_PIN_MASK) == 0 && bus_rack)
        else $error("port 12 clock pins not read as 0");
    a_unmapped_zero: assert property (@(posedge mclk) disable iff (!rstn)
        bus_rd && rd_sel == `READ_NONE |=> bus_rdata == 0)
        else $error("unmapped read not zero");
    a_dir_readback: assert property (@(posedge mclk) disable iff (!rstn)
        we_p3_dir && !bus_bit_op ##1 !bus_wr ##1 bus_rd && hit_p3_dir
        && !bus_wr |=> bus_rdata == ($past(bus_wdata, 3) | ~PORT3_MASK))
        else $error("direction byte write not read back");
endmodule

`default_nettype wire

// *** shared/port_regs.svh ***
/*
 * Addresses, reset values and bit masks of the three general-purpose ports.
 * Assumes a 16-bit address space with one byte per register.
 */
`ifndef PORT_REGS_SVH
`define PORT_REGS_SVH

// Register addresses
`define PORT2_DATA_ADDR 16'hff02
`define PORT3_DATA_ADDR 16'hff03
`define PORT12_DATA_ADDR 16'hff0c
`define PORT2_DIR_ADDR 16'hff22
`define PORT3_DIR_ADDR 16'hff23
`define PORT12_DIR_ADDR 16'hff2c
`define PORT3_PULLUP_ADDR 16'hff33
`define PORT12_PULLUP_ADDR 16'hff3c

// Reset values
`define DIR_RESET 8'hff
`define DATA_RESET 8'h00
`define PULLUP_RESET 8'h00
`define PORT12_PULLUP_RESET 8'h20
`define READ_NONE 8'h00

// Implemented bits, 16-pin variant
`define PORT2_IMPL_MASK 8'he7
`define PORT3_IMPL_MASK 8'h07
`define PORT12_DIR_MASK 8'h06
`define PORT12_DATA_MASK 8'h26
`define PORT3_PULLUP_MASK 8'h07
`define PORT12_PULLUP_MASK 8'h20
`define NO_PULLUP_MASK 8'h00

// Port 12 bits shared with the main oscillator
`define CLK_PIN_MASK 8'h06

`endif

// *** shared/port_pkg.sv ***
/*
 * Types shared by the port logic.
 * Assumes port_regs.svh supplies the numeric constants.
 */
package port_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [15:0] addr_t;
    typedef logic [2:0] bit_idx_t;
endpackage

// *** design/port_unit.sv ***
/*
 * One 8-bit port: direction, output latch and pull-up select registers,
 * pin synchroniser, pin drive and pull-up gating.
 * Assumes write strobes are already decoded and last one mclk cycle.
 */
`timescale 1ns/100ps
`default_nettype none
`include "port_regs.svh"

module port_unit #(
    parameter logic [7:0] DIR_MASK = `PORT2_IMPL_MASK,
    parameter logic [7:0] DAT_MASK = `PORT2_IMPL_MASK,
    parameter logic [7:0] PU_MASK = `NO_PULLUP_MASK,
    parameter logic [7:0] PU_RESET = `PULLUP_RESET
) (
    input wire logic mclk, // System clock
    input wire logic rstn, // Async reset, low
    input wire logic dir_we, // Direction write strobe
    input wire logic dat_we, // Latch write strobe
    input wire logic pu_we, // Pull-up select write strobe
    input wire logic bit_op, // 1: single-bit write
    input wire port_pkg::bit_idx_t bit_idx, // Bit for single-bit write
    input wire port_pkg::byte_t wdata, // Write data
    input wire port_pkg::byte_t pin_in, // Pin levels, asynchronous
    input wire port_pkg::byte_t alt_out, // Alternate output in use
    input wire port_pkg::byte_t clk_pins, // Bits taken by oscillator
    output port_pkg::byte_t dir_rd, // Direction readback
    output port_pkg::byte_t dat_rd, // Data readback
    output port_pkg::byte_t pu_rd, // Pull-up select readback
    output port_pkg::byte_t pin_out, // Pin output level
    output port_pkg::byte_t pin_oe_n, // Pin drive enable, low drives
    output port_pkg::byte_t pullup_on // Pull-up connect
);
    import port_pkg::*;

    byte_t dir_q, dat_q, pu_q;
    byte_t sync1, sync2, sync3, pin_q;
    byte_t next_dir, next_dat, next_pu, pin_agree;
    logic first_q;

    // Replace one bit or the whole byte
    function automatic byte_t merge(byte_t old, logic op, bit_idx_t idx,
                                    byte_t wd);
        byte_t r;
        r = old;
        if (op) begin
            r[idx] = wd[0];
        end else begin
            r = wd;
        end
        return r;
    endfunction

    // Missing direction bits stick at input, missing data bits at zero
    assign next_dir = merge(dir_q, bit_op, bit_idx, wdata) | ~DIR_MASK;
    assign next_dat = merge(dat_q, bit_op, bit_idx, wdata) & DAT_MASK;
    assign next_pu = merge(pu_q, bit_op, bit_idx, wdata) & PU_MASK;

    // Register file; the latch is written in either mode
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dir_q <= `DIR_RESET;
            dat_q <= `DATA_RESET;
            pu_q <= PU_RESET;
        end else begin
            if (dir_we) dir_q <= next_dir;
            if (dat_we) dat_q <= next_dat;
            if (pu_we) pu_q <= next_pu;
        end
    end

    // Three stages; a change is taken once stages two and three agree
    assign pin_agree = ~(sync2 ^ sync3);
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sync1 <= `DATA_RESET;
            sync2 <= `DATA_RESET;
            sync3 <= `DATA_RESET;
            pin_q <= `DATA_RESET;
        end else begin
            sync1 <= pin_in;
            sync2 <= sync1;
            sync3 <= sync2;
            pin_q <= (sync3 & pin_agree) | (pin_q & ~pin_agree);
        end
    end

    // Input bits show the pin, output bits the latch; clock pins read 0
    assign dat_rd = ((dir_q & pin_q) | (~dir_q & dat_q)) & DAT_MASK
                    & ~clk_pins;
    assign dir_rd = dir_q;
    assign pu_rd = pu_q;
    assign pin_out = dat_q;
    assign pin_oe_n = dir_q | clk_pins;
    // Pull-up only on input bits not carrying an alternate output
    assign pullup_on = pu_q & dir_q & ~alt_out & ~clk_pins;

    // Marks the first edge after reset release
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) first_q <= 1'b0;
        else first_q <= 1'b1;
    end

    a_reset_values: assert property (@(posedge mclk) disable iff (!rstn)
        !first_q |-> dir_q == `DIR_RESET && dat_q == `DATA_RESET
                     && pu_q == PU_RESET)
        else $error("register not at reset value after release");
    a_missing_bits: assert property (@(posedge mclk) disable iff (!rstn)
        (dir_rd | DIR_MASK) == `DIR_RESET && (dat_rd & ~DAT_MASK) == 0)
        else $error("unimplemented bit reads wrong");
    a_byte_write: assert property (@(posedge mclk) disable iff (!rstn)
        dat_we && !bit_op |=> pin_out == ($past(wdata) & DAT_MASK))
        else $error("latch missed byte write");
    a_bit_keep: assert property (@(posedge mclk) disable iff (!rstn)
        dat_we && bit_op |=> ((pin_out ^ $past(pin_out))
            & ~(8'h01 << $past(bit_idx))) == 0)
        else $error("bit write touched other bits");
    a_output_read: assert property (@(posedge mclk) disable iff (!rstn)
        ((dat_rd ^ dat_q) & ~dir_q & DAT_MASK & ~clk_pins) == 0)
        else $error("output bit not read from latch");
    a_input_read: assert property (@(posedge mclk) disable iff (!rstn)
        $changed(sync3) && sync2 == sync3 ##1 1'b1 |->
        ((dat_rd ^ $past(sync3)) & dir_q & DAT_MASK & ~clk_pins) == 0)
        else $error("input bit not read from pin");
    a_pullup_gate: assert property (@(posedge mclk) disable iff (!rstn)
        (pullup_on & (~dir_q | alt_out | ~pu_q)) == 0)
        else $error("pull-up on output or unselected bit");
    a_drive_dir: assert property (@(posedge mclk) disable iff (!rstn)
        dir_we && !bit_op |=> (pin_oe_n & ~clk_pins)
        == (($past(wdata) | ~DIR_MASK) & ~clk_pins))
        else $error("drive enable not following direction");
endmodule

`default_nettype wire

// *** verif/pin_model.sv ***
/*
 * Pin-side circuit model for one 8-bit port.
 * Assumes each pin has an external driver that the bench may release.
 */
`timescale 1ns/100ps
`default_nettype none

module pin_model (
    input wire port_pkg::byte_t pin_out, // Level the port drives
    input wire port_pkg::byte_t pin_oe_n, // Port drives when low
    input wire port_pkg::byte_t pullup_on, // On-chip pull-up connected
    input wire port_pkg::byte_t ext_val, // External driver level
    input wire port_pkg::byte_t ext_en, // External driver enabled
    output var port_pkg::byte_t pin_in // Resolved pin level
);
    import port_pkg::*;

    // Port drive wins, then the outside driver, then the pull-up; a line
    // left floating shows the inverse of the latch so a latch read in place of the pin never passes
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = ext_val[i];
            else if (pullup_on[i])
                pin_in[i] = 1'b1;
            else
                pin_in[i] = ~pin_out[i];
        end
    end
endmodule

`default_nettype wire

// *** verif/port_direction_data_pullup_tb_top.sv ***
/*
 * Self-checking bench for the port block: register table walk, then
 * hand-written input, bit-write, oscillator and reset cases.
 * Assumes pin_model.sv stands in for the board on all three ports.
 */
`timescale 1ns/100ps
`default_nettype none
`include "port_regs.svh"

module port_direction_data_pullup_tb_top;
    import port_pkg::*;

    typedef struct {addr_t a; byte_t w; byte_t r;} row_t;
    logic mclk, rstn, bus_wr, bus_rd, bus_bit_op, bus_rack, osc_pin_mode;
    addr_t bus_addr;
    bit_idx_t bus_bit_idx;
    byte_t bus_wdata, bus_rdata, ext_en, p2_ev, p3_ev, p12_ev;
    byte_t p2_alt, p3_alt, p12_alt, p2_in, p3_in, p12_in;
    byte_t p2_out, p3_out, p12_out, p2_oe_n, p3_oe_n, p12_oe_n;
    byte_t p2_pu, p3_pu, p12_pu;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    // Write, then read back; unmapped and missing bits included
    row_t rows [9] = '{
        '{`PORT2_DIR_ADDR, 8'h00, 8'h18},
        '{`PORT2_DATA_ADDR, 8'ha5, 8'ha5},
        '{`PORT3_DIR_ADDR, 8'hf8, 8'hf8},
        '{`PORT3_DATA_ADDR, 8'h05, 8'h05},
        '{`PORT12_DIR_ADDR, 8'hf9, 8'hf9},
        '{`PORT12_DATA_ADDR, 8'hff, 8'h06},
        '{`PORT3_PULLUP_ADDR, 8'hff, 8'h07},
        '{`PORT12_PULLUP_ADDR, 8'hff, 8'h20},
        '{16'hff10, 8'hff, 8'h00}
    };

    port_direction_data_pullup uut (
        .mclk(mclk), .rstn(rstn), .bus_addr(bus_addr), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_bit_op(bus_bit_op), .bus_bit_idx(bus_bit_idx),
        .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rack(bus_rack),
        .osc_pin_mode(osc_pin_mode), .p2_alt_out(p2_alt),
        .p3_alt_out(p3_alt), .p12_alt_out(p12_alt),
        .p2_pin_in(p2_in), .p2_pin_out(p2_out), .p2_pin_oe_n(p2_oe_n),
        .p2_pullup_on(p2_pu), .p3_pin_in(p3_in), .p3_pin_out(p3_out),
        .p3_pin_oe_n(p3_oe_n), .p3_pullup_on(p3_pu), .p12_pin_in(p12_in),
        .p12_pin_out(p12_out), .p12_pin_oe_n(p12_oe_n),
        .p12_pullup_on(p12_pu)
    );
    pin_model p2_pins (.pin_out(p2_out), .pin_oe_n(p2_oe_n),
        .pullup_on(p2_pu), .ext_val(p2_ev), .ext_en(ext_en), .pin_in(p2_in));
    pin_model p3_pins (.pin_out(p3_out), .pin_oe_n(p3_oe_n),
        .pullup_on(p3_pu), .ext_val(p3_ev), .ext_en(ext_en), .pin_in(p3_in));
    pin_model p12_pins (.pin_out(p12_out), .pin_oe_n(p12_oe_n),
        .pullup_on(p12_pu), .ext_val(p12_ev), .ext_en(ext_en),
        .pin_in(p12_in));

    // 25 MHz clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic give_verdict();
        if (errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic cmp(input string name, input byte_t exp, input byte_t got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Write strobe held one cycle; the next call waits a fresh edge
    task automatic wr(input addr_t a, input byte_t d, input logic bo,
                      input bit_idx_t bi);
        @(posedge mclk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_bit_op <= bo;
        bus_bit_idx <= bi;
        bus_wr <= 1'b1;
        @(posedge mclk);
        bus_wr <= 1'b0;
    endtask

    // Answer lands on the taking edge, so look just after it
    task automatic rd(input addr_t a, input byte_t exp);
        @(posedge mclk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge mclk);
        bus_rd <= 1'b0;
        #1;
        cmp("read ack", 8'h01, {7'h00, bus_rack});
        cmp("read data", exp, bus_rdata);
    endtask

    // Hang guard, far above the fewer than a hundred cycles the run needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            give_verdict();
        end
    end

    initial begin
        {bus_addr, bus_wdata, bus_bit_idx} = '0;
        {bus_wr, bus_rd, bus_bit_op, osc_pin_mode} = '0;
        {p2_alt, p3_alt, p12_alt, p2_ev, p3_ev, p12_ev} = '0;
        ext_en = 8'hff;
        rstn = 1'b0;
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            wr(rows[i].a, rows[i].w, 1'b0, 3'h0);
            rd(rows[i].a, rows[i].r);
        end
        cmp("p2 drive", 8'h18, p2_oe_n);
        cmp("p2 level", 8'ha5, p2_out);
        cmp("p3 pull-up", 8'h00, p3_pu);
        cmp("p12 pull-up", 8'h20, p12_pu);
        cmp("p12 level", 8'h26, p12_out);
        cmp("p3 drive", 8'hf8, p3_oe_n);
        cmp("p2 pull-up", 8'h00, p2_pu);
        // Latch written while in input mode, pin read through the sync
        wr(`PORT3_DIR_ADDR, 8'hff, 1'b0, 3'h0);
        wr(`PORT3_DATA_ADDR, 8'h02, 1'b0, 3'h0);
        p3_ev <= 8'h05;
        p3_alt <= 8'h01;
        repeat (5) @(posedge mclk);
        #1;
        cmp("p3 pull-up alt", 8'h06, p3_pu);
        rd(`PORT3_DATA_ADDR, 8'h05);
        wr(`PORT3_DIR_ADDR, 8'hf8, 1'b0, 3'h0);
        rd(`PORT3_DATA_ADDR, 8'h02);
        cmp("p3 level", 8'h02, p3_out);
        // Single-bit writes leave neighbours alone
        wr(`PORT3_DIR_ADDR, 8'h01, 1'b1, 3'h1);
        rd(`PORT3_DIR_ADDR, 8'hfa);
        wr(`PORT3_DATA_ADDR, 8'h01, 1'b1, 3'h0);
        rd(`PORT3_DATA_ADDR, 8'h01);
        // Oscillator takes port 12 clock pins
        @(posedge mclk);
        osc_pin_mode <= 1'b1;
        rd(`PORT12_DATA_ADDR, 8'h00);
        cmp("p12 drive", 8'hff, p12_oe_n);
        // Second reset in mid-run
        @(posedge mclk);
        osc_pin_mode <= 1'b0;
        rstn <= 1'b0;
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        #1;
        cmp("p2 drive rst", 8'hff, p2_oe_n);
        cmp("p3 level rst", 8'h00, p3_out);
        cmp("p12 pull-up rst", 8'h20, p12_pu);
        rd(`PORT2_DIR_ADDR, 8'hff);
        rd(`PORT3_PULLUP_ADDR, 8'h00);
        rd(`PORT12_PULLUP_ADDR, 8'h20);
        rd(`PORT3_DATA_ADDR, 8'h05);
        give_verdict();
    end
endmodule

`default_nettype wire
